// *** rtl/ltmc_top.sv ***
// LIN transceiver cell mode and failure control for three cells
`timescale 1ns/1ps
`include "ltmc_defines.svh"
// Overview of operation
// - Three identical cells, sharing slope, interrupt, restart and diagnostics
// - Normal mode by request only, flash mode by flash entry
// - Low slope 10.4k, normal slope 20k
// - Global slope, resets low, set in normal
// - Off mode left by request, or forced out in flash or fail-safe chip mode
// - Wake mode by request, forced in fail-safe
// - No wake re-arm before intermediate mode
// - Sleep wake: restart, receive low, no interrupt
// - Stop wake: flag, interrupt, receive low
// - Receive-only ignores transmit, passes bus
// - Flash mode bypasses slope, flash-only
// - Cell modes limited by chip mode
// - Pull-up off in off and wake modes; wake on rising bus edge
// - Failure forces receive-only until request
// - Failures reported, overtemperature silent
// - Transmit dominant time-out stops driving
// - Bus dominant clamp: receive-only, flag, interrupt
// - Transmit-receive short inhibits transmitter
// - Overtemperature release on transmit rising edge
// - Receive recessive clamp inhibits transmitter
module ltmc_top #(
  parameter int unsigned WAKE_FILT_CYC = `LTMC_WAKE_FILT_CYC,
  parameter int unsigned TXD_TO_CYC = `LTMC_TXD_TO_CYC,
  parameter int unsigned BUS_TO_CYC = `LTMC_BUS_TO_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Chip mode
  input wire ltmc_pkg::ltmc_chip_t host_chip_mode,
  // Mode and slope requests
  input wire logic mode_req_valid,
  input wire logic [1:0] mode_req_cell,
  input wire ltmc_pkg::ltmc_req_t mode_req_mode,
  input wire logic slope_wr_valid,
  input wire logic slope_wr_normal,
  // Flag clears and interrupt masks
  input wire logic [2:0] wake_flag_clr,
  input wire logic [2:0] fail_flag_clr,
  input wire logic int_mask_wake,
  input wire logic int_mask_fail,
  // Pins, asynchronous
  input wire logic [2:0] txd_pin,
  input wire logic [2:0] lin_bus_line,
  input wire logic [2:0] rxd_fb_pin,
  input wire logic [2:0] ot_pin,
  // Cell outputs
  output logic [2:0] lin_receive_output,
  output logic [2:0] bus_drive_dom,
  output logic [2:0] pullup_en,
  output logic [2:0] slope_bypass,
  output logic low_slope,
  output logic [2:0][4:0] cell_mode_stat,
  // Status and events
  output logic [2:0] lin_wake_flag,
  output logic [2:0] bus_clamp_flag,
  output logic int_n,
  output logic restart_req,
  // Diagnostic words
  output logic diag_valid,
  output logic [`LTMC_DIAG_W-1:0] diag_data,
  input wire logic diag_ready
);
  localparam int unsigned CW = `LTMC_CNT_W;
  localparam int unsigned MW = `LTMC_MIS_W;
  localparam logic [CW-1:0] WAKE_Q = CW'(WAKE_FILT_CYC);
  localparam logic [CW-1:0] TXD_Q = CW'(TXD_TO_CYC - 1);
  localparam logic [CW-1:0] BUS_Q = CW'(BUS_TO_CYC - 1);
  localparam logic [MW-1:0] MIS_Q = MW'(`LTMC_MIS_CYC - 1);

  // Which cell modes each chip mode allows
  function automatic logic mode_ok(input ltmc_pkg::ltmc_chip_t c,
                                   input ltmc_pkg::ltmc_cell_t m);
    logic r;
    r = 1'b0;
    unique case (c)
      ltmc_pkg::CHIP_INIT: r = (m == ltmc_pkg::CM_OFF);
      ltmc_pkg::CHIP_NORMAL: r = (m != ltmc_pkg::CM_FLASH);
      ltmc_pkg::CHIP_SLEEP, ltmc_pkg::CHIP_RESTART, ltmc_pkg::CHIP_STOP:
        r = (m == ltmc_pkg::CM_OFF) || (m == ltmc_pkg::CM_WAKE);
      ltmc_pkg::CHIP_FAILSAFE: r = (m == ltmc_pkg::CM_WAKE);
      ltmc_pkg::CHIP_FLASH: r = (m == ltmc_pkg::CM_FLASH);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic ltmc_pkg::ltmc_cell_t req_mode(input ltmc_pkg::ltmc_req_t q);
    ltmc_pkg::ltmc_cell_t m;
    m = ltmc_pkg::CM_OFF;
    unique case (q)
      ltmc_pkg::REQ_OFF: m = ltmc_pkg::CM_OFF;
      ltmc_pkg::REQ_WAKE: m = ltmc_pkg::CM_WAKE;
      ltmc_pkg::REQ_NORM: m = ltmc_pkg::CM_NORM;
      ltmc_pkg::REQ_RXO: m = ltmc_pkg::CM_RXO;
    endcase
    return m;
  endfunction

  // Two-stage pin synchronisers; only stage two is read
  logic [11:0] pin_s1_r;
  logic [11:0] pin_s2_r;
  logic [2:0] txd_s;
  logic [2:0] bus_s;
  logic [2:0] fb_s;
  logic [2:0] ot_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r <= 12'hFFF;
      pin_s2_r <= 12'hFFF;
    end else begin
      pin_s1_r <= {~ot_pin, rxd_fb_pin, lin_bus_line, txd_pin};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign txd_s = pin_s2_r[2:0];
  assign bus_s = pin_s2_r[5:3];
  assign fb_s = pin_s2_r[8:6];
  assign ot_s = ~pin_s2_r[11:9];

  // Shared chip-wide slope, only written in chip normal mode
  wire slope_wr = slope_wr_valid && (host_chip_mode == ltmc_pkg::CHIP_NORMAL);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) low_slope <= `LTMC_LOW_SLOPE_RST;
    else if (slope_wr) low_slope <= !slope_wr_normal;
  end

  // Per-cell results gathered for shared outputs
  logic [2:0] wake_int;
  logic [2:0] wake_rst;
  logic [11:0] pend_set;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  genvar gi;
  generate
    for (gi = 0; gi < `LTMC_NCELL; gi++) begin : g_cell
      ltmc_pkg::ltmc_cell_t mode_r;
      ltmc_pkg::ltmc_cell_t mode_nxt;
      logic [CW-1:0] txd_cnt_r;
      logic [CW-1:0] bus_cnt_r;
      logic [MW-1:0] mis_cnt_r;
      logic txd_prev_r;
      logic bus_prev_r;
      logic woke_r;
      logic txd_to_r;
      logic clamp_r;
      logic short_r;
      logic rxdc_r;
      logic ot_blk_r;
      logic wake_int_r;

      wire txd_dom = !txd_s[gi];
      wire bus_dom = !bus_s[gi];
      wire m_norm = (mode_r == ltmc_pkg::CM_NORM);
      wire m_wake = (mode_r == ltmc_pkg::CM_WAKE);
      wire m_rx = m_norm || (mode_r == ltmc_pkg::CM_RXO) || (mode_r == ltmc_pkg::CM_FLASH);
      wire m_tx = m_norm || (mode_r == ltmc_pkg::CM_FLASH);

      wire ltmc_pkg::ltmc_cell_t rq_m = req_mode(mode_req_mode);
      wire req_hit = mode_req_valid && (mode_req_cell == 2'(gi));
      wire req_ok = req_hit && mode_ok(host_chip_mode, rq_m)
                    && !((rq_m == ltmc_pkg::CM_WAKE) && woke_r);
      wire norm_req = req_ok && (rq_m == ltmc_pkg::CM_NORM);

      wire txd_to_ev = m_tx && txd_dom && (txd_cnt_r == TXD_Q);
      wire bus_to_ev = m_tx && bus_dom && (bus_cnt_r == BUS_Q);
      wire mis_ev = m_rx && (fb_s[gi] != lin_receive_output[gi]) && (mis_cnt_r == MIS_Q);
      wire short_ev = mis_ev && (fb_s[gi] == txd_s[gi]);
      wire rxdc_ev = mis_ev && (fb_s[gi] != txd_s[gi]) && fb_s[gi];
      wire fault_ev = txd_to_ev || bus_to_ev || short_ev || rxdc_ev;
      // Only a rising bus edge after a filtered dominant phase wakes,
      // so a bus stuck at ground never does
      wire wake_ev = m_wake && !woke_r && bus_s[gi] && !bus_prev_r
                     && (bus_cnt_r >= WAKE_Q);
      wire fault = txd_to_r || clamp_r || short_r || rxdc_r;
      wire tx_inh = fault || ot_blk_r;

      // Chip mode forcing takes priority over requests and faults
      assign mode_nxt =
        (host_chip_mode == ltmc_pkg::CHIP_INIT) ? ltmc_pkg::CM_OFF :
        (host_chip_mode == ltmc_pkg::CHIP_FLASH) ? ltmc_pkg::CM_FLASH :
        (host_chip_mode == ltmc_pkg::CHIP_FAILSAFE) ? ltmc_pkg::CM_WAKE :
        !mode_ok(host_chip_mode, mode_r) ? ltmc_pkg::CM_OFF :
        (m_norm && fault_ev) ? ltmc_pkg::CM_RXO :
        req_ok ? rq_m : mode_r;

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) mode_r <= ltmc_pkg::ltmc_cell_t'(`LTMC_CELL_RST);
        else mode_r <= mode_nxt;
      end

      // Saturating dominant-time and readback mismatch counters
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          txd_cnt_r <= '0;
          bus_cnt_r <= '0;
          mis_cnt_r <= '0;
          txd_prev_r <= 1'b1;
          bus_prev_r <= 1'b1;
        end else begin
          txd_cnt_r <= !txd_dom ? '0 : txd_cnt_r + CW'(txd_cnt_r != '1);
          bus_cnt_r <= !bus_dom ? '0 : bus_cnt_r + CW'(bus_cnt_r != '1);
          mis_cnt_r <= (fb_s[gi] == lin_receive_output[gi]) ? '0
                       : mis_cnt_r + MW'(mis_cnt_r != '1);
          txd_prev_r <= txd_s[gi];
          bus_prev_r <= bus_s[gi];
        end
      end

      // Fault latches; a new fault wins over a release in the same cycle
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          txd_to_r <= 1'b0;
          clamp_r <= 1'b0;
          short_r <= 1'b0;
          rxdc_r <= 1'b0;
        end else begin
          txd_to_r <= txd_to_ev || (txd_to_r && !norm_req);
          clamp_r <= bus_to_ev || (clamp_r && !norm_req);
          short_r <= short_ev || (short_r && !norm_req);
          rxdc_r <= rxdc_ev || (rxdc_r && !norm_req);
        end
      end

      // Overtemperature blocks until it ends and transmit goes recessive
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) ot_blk_r <= 1'b0;
        else ot_blk_r <= ot_s[gi] || (ot_blk_r && !(txd_s[gi] && !txd_prev_r));
      end

      // Wake bookkeeping
      wire wake_irq_mode = (host_chip_mode == ltmc_pkg::CHIP_STOP)
                           || (host_chip_mode == ltmc_pkg::CHIP_NORMAL);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          woke_r <= 1'b0;
          wake_int_r <= 1'b0;
          lin_wake_flag[gi] <= 1'b0;
          bus_clamp_flag[gi] <= 1'b0;
        end else begin
          woke_r <= wake_ev || (woke_r && (mode_nxt == ltmc_pkg::CM_WAKE));
          wake_int_r <= (wake_ev && wake_irq_mode)
                        || (wake_int_r && !wake_flag_clr[gi]);
          lin_wake_flag[gi] <= wake_ev || (lin_wake_flag[gi] && !wake_flag_clr[gi]);
          bus_clamp_flag[gi] <= bus_to_ev || (bus_clamp_flag[gi] && !fail_flag_clr[gi]);
        end
      end
      assign wake_int[gi] = wake_int_r;
      assign wake_rst[gi] = wake_ev && !wake_irq_mode;
      // Overtemperature is deliberately not queued
      assign pend_set[gi*4 +: 4] = {rxdc_ev, short_ev, bus_to_ev, txd_to_ev};

      // Registered pin-side outputs
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          lin_receive_output[gi] <= 1'b1;
          bus_drive_dom[gi] <= 1'b0;
          pullup_en[gi] <= 1'b0;
          slope_bypass[gi] <= 1'b0;
          cell_mode_stat[gi] <= `LTMC_CELL_RST;
        end else begin
          lin_receive_output[gi] <= m_rx ? bus_s[gi] : !(m_wake && woke_r);
          bus_drive_dom[gi] <= m_tx && txd_dom && !tx_inh;
          pullup_en[gi] <= m_rx;
          slope_bypass[gi] <= (mode_r == ltmc_pkg::CM_FLASH);
          cell_mode_stat[gi] <= mode_r;
        end
      end

      property p_chip_force;
        (host_chip_mode == ltmc_pkg::CHIP_INIT) |=> (mode_r == ltmc_pkg::CM_OFF);
      endproperty
      a_chip_force: assert property (p_chip_force) else $error("cell not off in init");

      property p_flash;
        (host_chip_mode == ltmc_pkg::CHIP_FLASH)
          |=> (mode_r == ltmc_pkg::CM_FLASH) ##1 slope_bypass[gi];
      endproperty
      a_flash: assert property (p_flash) else $error("flash mode not entered");

      property p_failsafe;
        (host_chip_mode == ltmc_pkg::CHIP_FAILSAFE) |=> (mode_r == ltmc_pkg::CM_WAKE);
      endproperty
      a_failsafe: assert property (p_failsafe) else $error("wake not forced");

      sequence s_txd_trip;
        txd_to_ev ##1 txd_to_r;
      endsequence
      property p_txd_to;
        s_txd_trip |=> !bus_drive_dom[gi];
      endproperty
      a_txd_to: assert property (p_txd_to) else $error("driver active after time-out");

      property p_clamp;
        (bus_to_ev && m_norm && host_chip_mode == ltmc_pkg::CHIP_NORMAL)
          |=> (mode_r == ltmc_pkg::CM_RXO) && bus_clamp_flag[gi];
      endproperty
      a_clamp: assert property (p_clamp) else $error("clamp did not force receive-only");

      property p_rearm;
        (woke_r && req_hit && rq_m == ltmc_pkg::CM_WAKE && m_wake
         && host_chip_mode == ltmc_pkg::CHIP_NORMAL) |=> m_wake && woke_r;
      endproperty
      a_rearm: assert property (p_rearm) else $error("wake re-armed directly");

      property p_bad_req;
        (req_hit && !mode_ok(host_chip_mode, rq_m) && mode_ok(host_chip_mode, mode_r)
         && !fault_ev) |=> $stable(mode_r);
      endproperty
      a_bad_req: assert property (p_bad_req) else $error("disallowed request acted on");

      sequence s_stop_wake;
        wake_ev && host_chip_mode == ltmc_pkg::CHIP_STOP;
      endsequence
      property p_stop_wake;
        s_stop_wake |=> lin_wake_flag[gi] && !restart_req ##1 !lin_receive_output[gi];
      endproperty
      a_stop_wake: assert property (p_stop_wake) else $error("stop wake not flagged");

      property p_pullup;
        (mode_r == ltmc_pkg::CM_WAKE || mode_r == ltmc_pkg::CM_OFF) |=> !pullup_en[gi];
      endproperty
      a_pullup: assert property (p_pullup) else $error("pull-up on in low-power mode");

      property p_ot;
        ot_blk_r |=> !bus_drive_dom[gi];
      endproperty
      a_ot: assert property (p_ot) else $error("driver active under overtemperature");
    end
  endgenerate

  // Interrupt and restart request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_n <= 1'b1;
      restart_req <= 1'b0;
    end else begin
      int_n <= !((|wake_int && !int_mask_wake)
                 || (|bus_clamp_flag && !int_mask_fail));
      restart_req <= |wake_rst;
    end
  end

  // Pending diagnostics, lowest index first; a new event wins over its own pop
  logic [11:0] pend_r;
  logic [3:0] pick;
  logic buf_ready;
  always_comb begin
    pick = 4'h0;
    for (int k = 11; k >= 0; k--) begin
      if (pend_r[k]) pick = 4'(k);
    end
  end
  wire push = |pend_r && buf_ready;
  wire [11:0] pop_mask = push ? (12'h001 << pick) : 12'h000;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pend_r <= 12'h000;
    else pend_r <= (pend_r & ~pop_mask) | pend_set;
  end

  // Buffer keeps a stalled reader from losing a word
  ltmc_skid #(.W(`LTMC_DIAG_W)) u_diag_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(|pend_r),
    .in_data(pick),
    .in_ready(buf_ready),
    .out_valid(diag_valid),
    .out_data(diag_data),
    .out_ready(diag_ready)
  );

  property p_slope;
    (slope_wr_valid && host_chip_mode != ltmc_pkg::CHIP_NORMAL) |=> $stable(low_slope);
  endproperty
  a_slope: assert property (p_slope) else $error("slope changed outside normal");

  property p_sleep_wake;
    (|wake_rst && host_chip_mode == ltmc_pkg::CHIP_SLEEP) |=> restart_req ##1 1'b1;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake without restart");
endmodule // ltmc_top

// *** rtl/ltmc_defines.svh ***
// Constants for the LIN cell mode control block
`ifndef LTMC_DEFINES_SVH
`define LTMC_DEFINES_SVH

`define LTMC_CLK_PERIOD_NS 5
`define LTMC_NCELL 3
`define LTMC_CNT_W 17
`define LTMC_MIS_W 8
`define LTMC_DIAG_W 4

// Least times, rounded up to whole cycles
`define LTMC_WAKE_FILT_NS 30000
`define LTMC_WAKE_FILT_CYC \
  ((`LTMC_WAKE_FILT_NS + `LTMC_CLK_PERIOD_NS - 1) / `LTMC_CLK_PERIOD_NS)
`define LTMC_TXD_TO_NS 300000
`define LTMC_TXD_TO_CYC \
  ((`LTMC_TXD_TO_NS + `LTMC_CLK_PERIOD_NS - 1) / `LTMC_CLK_PERIOD_NS)
`define LTMC_BUS_TO_NS 300000
`define LTMC_BUS_TO_CYC \
  ((`LTMC_BUS_TO_NS + `LTMC_CLK_PERIOD_NS - 1) / `LTMC_CLK_PERIOD_NS)
`define LTMC_MIS_NS 1000
`define LTMC_MIS_CYC \
  ((`LTMC_MIS_NS + `LTMC_CLK_PERIOD_NS - 1) / `LTMC_CLK_PERIOD_NS)

// Reset values
`define LTMC_LOW_SLOPE_RST 1'b1
`define LTMC_CELL_RST 5'h01

`endif

// *** rtl/ltmc_pkg.sv ***
// Types for the LIN cell mode control block
package ltmc_pkg;
  typedef enum logic [2:0] {
    CHIP_INIT = 3'h0,
    CHIP_NORMAL = 3'h1,
    CHIP_SLEEP = 3'h2,
    CHIP_RESTART = 3'h3,
    CHIP_STOP = 3'h4,
    CHIP_FAILSAFE = 3'h5,
    CHIP_FLASH = 3'h6
  } ltmc_chip_t;

  typedef enum logic [4:0] {
    CM_OFF = 5'h01,
    CM_WAKE = 5'h02,
    CM_NORM = 5'h04,
    CM_RXO = 5'h08,
    CM_FLASH = 5'h10
  } ltmc_cell_t;

  typedef enum logic [1:0] {
    REQ_OFF = 2'h0,
    REQ_WAKE = 2'h1,
    REQ_NORM = 2'h2,
    REQ_RXO = 2'h3
  } ltmc_req_t;

  typedef enum logic [1:0] {
    DG_TXD_GND = 2'h0,
    DG_BUS_CLAMP = 2'h1,
    DG_TXRX_SHORT = 2'h2,
    DG_RXD_CLAMP = 2'h3
  } ltmc_diag_t;
endpackage

// *** rtl/ltmc_skid.sv ***
// Two-entry buffer for diagnostic words
`timescale 1ns/1ps
`include "ltmc_defines.svh"
module ltmc_skid #(
  parameter int unsigned W = `LTMC_DIAG_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic sp_valid_r;
  logic [W-1:0] sp_data_r;
  wire take = in_valid && in_ready;
  wire head_free = !out_valid || out_ready;

  // Ready is a flop, so the filling side never sees a combinational path
  assign in_ready = !sp_valid_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      sp_valid_r <= 1'b0;
      sp_data_r <= '0;
    end else if (head_free) begin
      out_valid <= sp_valid_r || take;
      if (sp_valid_r) out_data <= sp_data_r;
      else if (take) out_data <= in_data;
      sp_valid_r <= 1'b0;
    end else if (take) begin
      sp_valid_r <= 1'b1;
      sp_data_r <= in_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer head dropped under stall");

  property p_no_loss;
    in_valid && in_ready |=> out_valid;
  endproperty
  a_no_loss: assert property (p_no_loss) else $error("accepted word not presented");
endmodule // ltmc_skid

// *** test/ltmc_lin_peer.sv ***
// Bus and pin model facing the three cells
`timescale 1ns/1ps
module ltmc_lin_peer (
  // Cell side
  input wire logic [2:0] bus_drive_dom,
  input wire logic [2:0] lin_receive_output,
  // Bench control
  input wire logic [2:0] txd_in,
  input wire logic [2:0] force_dom,
  input wire logic [2:0] fb_stuck,
  // Pins towards the cells
  output logic [2:0] txd_pin,
  output logic [2:0] lin_bus_line,
  output logic [2:0] rxd_fb_pin
);
  // Bus has a pull-up, so any dominant driver wins the wire
  assign lin_bus_line = ~(bus_drive_dom | force_dom);
  // Readback can be held high to mimic a short or a clamped receive pin
  assign rxd_fb_pin = lin_receive_output | fb_stuck;
  // Transmit pins pass straight through from the bench
  assign txd_pin = txd_in;
endmodule // ltmc_lin_peer

// *** test/ltmc_bench.sv ***
// Self-checking bench for the LIN cell mode control
`timescale 1ns/1ps
module ltmc_bench;
  localparam int WF = 20;
  localparam int TT = 20;
  localparam int BT = 50;
  logic clk, nrst, mode_req_valid, slope_wr_valid, slope_wr_normal;
  logic int_mask_wake, int_mask_fail, low_slope, int_n, restart_req, diag_valid, diag_ready;
  logic [1:0] mode_req_cell;
  logic [2:0] wake_flag_clr, fail_flag_clr, txd_in, force_dom, txd_pin, lin_bus_line;
  logic [2:0] rxd_fb_pin, ot_pin, lin_receive_output, bus_drive_dom, pullup_en, slope_bypass;
  logic [2:0] lin_wake_flag, bus_clamp_flag, fb_stuck;
  logic [2:0][4:0] cell_mode_stat;
  logic [3:0] diag_data;
  ltmc_pkg::ltmc_chip_t host_chip_mode;
  ltmc_pkg::ltmc_req_t mode_req_mode;
  int checks = 0;
  int n_fail = 0;
  int restart_cnt = 0;
  int i;
  logic [3:0] words[$];

  ltmc_top #(.WAKE_FILT_CYC(WF), .TXD_TO_CYC(TT), .BUS_TO_CYC(BT)) ltmc_top_inst (
    .clk(clk), .nrst(nrst), .host_chip_mode(host_chip_mode),
    .mode_req_valid(mode_req_valid), .mode_req_cell(mode_req_cell),
    .mode_req_mode(mode_req_mode), .slope_wr_valid(slope_wr_valid),
    .slope_wr_normal(slope_wr_normal), .wake_flag_clr(wake_flag_clr),
    .fail_flag_clr(fail_flag_clr), .int_mask_wake(int_mask_wake),
    .int_mask_fail(int_mask_fail), .txd_pin(txd_pin), .lin_bus_line(lin_bus_line),
    .rxd_fb_pin(rxd_fb_pin), .ot_pin(ot_pin), .lin_receive_output(lin_receive_output),
    .bus_drive_dom(bus_drive_dom), .pullup_en(pullup_en), .slope_bypass(slope_bypass),
    .low_slope(low_slope), .cell_mode_stat(cell_mode_stat), .lin_wake_flag(lin_wake_flag),
    .bus_clamp_flag(bus_clamp_flag), .int_n(int_n), .restart_req(restart_req),
    .diag_valid(diag_valid), .diag_data(diag_data), .diag_ready(diag_ready));

  ltmc_lin_peer ltmc_lin_peer_inst (
    .bus_drive_dom(bus_drive_dom), .lin_receive_output(lin_receive_output),
    .txd_in(txd_in), .force_dom(force_dom), .fb_stuck(fb_stuck), .txd_pin(txd_pin),
    .lin_bus_line(lin_bus_line), .rxd_fb_pin(rxd_fb_pin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (restart_req === 1'b1) restart_cnt++;
  end

  task stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task bound(input string name, input int n);
    if (n >= 200) begin
      n_fail++;
      $display("[FAIL] %s expected event seen none", name);
      stop_test();
    end
  endtask

  function logic [15:0] st();
    return {1'b0, cell_mode_stat};
  endfunction

  // A word standing at a falling edge with ready high is taken at the next rising edge
  task drain();
    words.delete();
    diag_ready = 1'b1;
    for (i = 0; i < 10; i++) begin
      if (diag_valid === 1'b1) words.push_back(diag_data);
      @(negedge clk);
    end
  endtask

  task req(input logic [1:0] c, input ltmc_pkg::ltmc_req_t m);
    @(negedge clk);
    mode_req_valid = 1'b1;
    mode_req_cell = c;
    mode_req_mode = m;
    @(negedge clk);
    mode_req_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task chip(input ltmc_pkg::ltmc_chip_t m);
    host_chip_mode = m;
    repeat (3) @(negedge clk);
  endtask

  task slope(input logic nrm);
    slope_wr_normal = nrm;
    slope_wr_valid = 1'b1;
    @(negedge clk);
    slope_wr_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task t_reset();
    cmp("mode", 16'h0421, st());
    cmp("low_slope", 16'h0001, low_slope);
    cmp("int_n", 16'h0001, int_n);
    cmp("pullup", 16'h0000, pullup_en);
    chip(ltmc_pkg::CHIP_INIT);
    req(2'h0, ltmc_pkg::REQ_NORM);
    cmp("mode", 16'h0421, st());
  endtask

  task t_modes();
    chip(ltmc_pkg::CHIP_STOP);
    slope(1'b1);
    cmp("low_slope", 16'h0001, low_slope);
    chip(ltmc_pkg::CHIP_NORMAL);
    slope(1'b1);
    cmp("low_slope", 16'h0000, low_slope);
    req(2'h0, ltmc_pkg::REQ_NORM);
    req(2'h1, ltmc_pkg::REQ_RXO);
    cmp("mode", 16'h0504, st());
    cmp("pullup", 16'h0003, pullup_en);
    txd_in = 3'h4;
    force_dom = 3'h2;
    repeat (6) @(negedge clk);
    cmp("drive", 16'h0001, bus_drive_dom);
    cmp("rx", 16'h0004, lin_receive_output);
    txd_in = 3'h7;
    force_dom = 3'h0;
    repeat (6) @(negedge clk);
  endtask

  task t_faults();
    diag_ready = 1'b0;
    txd_in = 3'h6;
    repeat (TT + 10) @(negedge clk);
    cmp("drive", 16'h0000, bus_drive_dom);
    cmp("mode", 16'h0508, st());
    cmp("diag", 16'h0010, {diag_valid, diag_data});
    txd_in = 3'h7;
    req(2'h1, ltmc_pkg::REQ_NORM);
    cmp("mode", 16'h0488, st());
    force_dom = 3'h2;
    repeat (BT + 10) @(negedge clk);
    force_dom = 3'h0;
    cmp("clamp", 16'h0002, bus_clamp_flag);
    cmp("int_n", 16'h0000, int_n);
    int_mask_fail = 1'b1;
    repeat (2) @(negedge clk);
    cmp("int_n", 16'h0001, int_n);
    int_mask_fail = 1'b0;
    repeat (2) @(negedge clk);
    cmp("mode", 16'h0508, st());
    cmp("diag", 16'h0010, {diag_valid, diag_data});
    @(negedge clk) fail_flag_clr = 3'h2;
    @(negedge clk) fail_flag_clr = 3'h0;
    repeat (3) @(negedge clk);
    cmp("int_n", 16'h0001, int_n);
    drain();
    cmp("words", 16'h0002, words.size());
    if (words.size() == 2) cmp("word", 16'h0005, {words[0], words[1]});
    req(2'h0, ltmc_pkg::REQ_NORM);
    req(2'h1, ltmc_pkg::REQ_NORM);
    cmp("mode", 16'h0484, st());
  endtask

  task t_overtemp();
    ot_pin = 3'h1;
    txd_in = 3'h6;
    repeat (6) @(negedge clk);
    cmp("drive", 16'h0000, bus_drive_dom);
    ot_pin = 3'h0;
    repeat (6) @(negedge clk);
    cmp("drive", 16'h0000, bus_drive_dom);
    txd_in = 3'h7;
    repeat (6) @(negedge clk);
    txd_in = 3'h6;
    repeat (6) @(negedge clk);
    cmp("drive", 16'h0001, bus_drive_dom);
    txd_in = 3'h7;
    repeat (6) @(negedge clk);
    cmp("mode", 16'h0484, st());
    cmp("int_n", 16'h0001, int_n);
    cmp("diag_valid", 16'h0000, diag_valid);
  endtask

  task t_readback();
    diag_ready = 1'b0;
    req(2'h1, ltmc_pkg::REQ_RXO);
    force_dom = 3'h2;
    fb_stuck = 3'h2;
    repeat (220) @(negedge clk);
    cmp("diag", 16'h0016, {diag_valid, diag_data});
    fb_stuck = 3'h0;
    txd_in = 3'h5;
    repeat (5) @(negedge clk);
    fb_stuck = 3'h2;
    repeat (220) @(negedge clk);
    txd_in = 3'h7;
    force_dom = 3'h0;
    fb_stuck = 3'h0;
    drain();
    cmp("words", 16'h0002, words.size());
    if (words.size() == 2) cmp("word", 16'h0067, {words[0], words[1]});
    req(2'h1, ltmc_pkg::REQ_NORM);
  endtask

  task t_stop_wake();
    req(2'h2, ltmc_pkg::REQ_WAKE);
    cmp("pullup", 16'h0003, pullup_en);
    chip(ltmc_pkg::CHIP_STOP);
    restart_cnt = 0;
    force_dom = 3'h4;
    repeat (2 * WF) @(negedge clk);
    cmp("wake", 16'h0000, lin_wake_flag);
    force_dom = 3'h0;
    for (i = 0; i < 200 && lin_wake_flag[2] !== 1'b1; i++) @(negedge clk);
    bound("wake", i);
    repeat (3) @(negedge clk);
    cmp("int_n", 16'h0000, int_n);
    int_mask_wake = 1'b1;
    repeat (2) @(negedge clk);
    cmp("int_n", 16'h0001, int_n);
    int_mask_wake = 1'b0;
    cmp("rx", 16'h0003, lin_receive_output);
    cmp("restart", 16'h0000, restart_cnt);
    @(negedge clk) wake_flag_clr = 3'h4;
    @(negedge clk) wake_flag_clr = 3'h0;
    repeat (3) @(negedge clk);
    cmp("int_n", 16'h0001, int_n);
  endtask

  task t_sleep_wake();
    chip(ltmc_pkg::CHIP_NORMAL);
    req(2'h2, ltmc_pkg::REQ_WAKE);
    cmp("rx2", 16'h0000, lin_receive_output[2]);
    req(2'h2, ltmc_pkg::REQ_OFF);
    req(2'h2, ltmc_pkg::REQ_WAKE);
    cmp("rx2", 16'h0001, lin_receive_output[2]);
    req(2'h0, ltmc_pkg::REQ_WAKE);
    chip(ltmc_pkg::CHIP_SLEEP);
    restart_cnt = 0;
    force_dom = 3'h1;
    repeat (2 * WF) @(negedge clk);
    force_dom = 3'h0;
    for (i = 0; i < 200 && lin_wake_flag[0] !== 1'b1; i++) @(negedge clk);
    bound("wake", i);
    repeat (3) @(negedge clk);
    cmp("restart", 16'h0001, restart_cnt);
    cmp("int_n", 16'h0001, int_n);
    cmp("rx0", 16'h0000, lin_receive_output[0]);
  endtask

  task t_chip_force();
    chip(ltmc_pkg::CHIP_FLASH);
    cmp("mode", 16'h4210, st());
    cmp("bypass", 16'h0007, slope_bypass);
    req(2'h0, ltmc_pkg::REQ_OFF);
    cmp("mode", 16'h4210, st());
    chip(ltmc_pkg::CHIP_FAILSAFE);
    cmp("mode", 16'h0842, st());
    chip(ltmc_pkg::CHIP_INIT);
    cmp("mode", 16'h0421, st());
  endtask

  initial begin
    nrst = 1'b0;
    host_chip_mode = ltmc_pkg::CHIP_INIT;
    mode_req_valid = 1'b0;
    mode_req_cell = 2'h0;
    mode_req_mode = ltmc_pkg::REQ_OFF;
    slope_wr_valid = 1'b0;
    slope_wr_normal = 1'b0;
    wake_flag_clr = 3'h0;
    fail_flag_clr = 3'h0;
    int_mask_wake = 1'b0;
    int_mask_fail = 1'b0;
    txd_in = 3'h7;
    force_dom = 3'h0;
    ot_pin = 3'h0;
    fb_stuck = 3'h0;
    diag_ready = 1'b1;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_modes();
    t_faults();
    t_overtemp();
    t_readback();
    t_stop_wake();
    t_sleep_wake();
    t_chip_force();
    stop_test();
  end

  initial begin
    #500000;
    n_fail++;
    $display("[FAIL] run expected end seen hang");
    stop_test();
  end
endmodule // ltmc_bench
